// ### design/synth_divider_program_regs.sv
// Write-only programming registers behind the three-wire serial port
`timescale 1ns/1ps

module synth_divider_program_regs (
  // Clock and reset
  input  wire logic                               core_clk,
  input  wire logic                               reset_n,
  // Three-wire serial port pins
  input  wire logic                               serial_clk_pin,
  input  wire logic                               serial_data_pin,
  input  wire logic                               serial_latch_pin,
  // Active divider settings
  output synth_prog_pkg::divider_settings_s       active_settings,
  output synth_prog_pkg::phase_control_s          phase_control,
  output logic [19:0]                             resync_clock_value,
  // Update events and state
  output logic                                    modulator_reset_pulse,
  output logic                                    calibration_start_pulse,
  output logic                                    vco_band_hold,
  output logic                                    update_pulse,
  // Word diagnostics
  output logic [3:0]                              last_select_code,
  output logic                                    word_length_error,
  output logic                                    reserved_bit_error
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic sclk_s;
  logic sdata_s;
  logic slatch_s;

  pin_sync u_sync_clk (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .pin_in    (serial_clk_pin),
    .level_out (sclk_s)
  );

  pin_sync u_sync_data (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .pin_in    (serial_data_pin),
    .level_out (sdata_s)
  );

  // Latch idles high: a low reset level would fake a latch edge on release
  pin_sync #(
    .RESET_LEVEL (1'b1)
  ) u_sync_latch (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .pin_in    (serial_latch_pin),
    .level_out (slatch_s)
  );

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  logic sclk_prev_r;
  logic slatch_prev_r;
  logic sclk_rise;
  logic latch_rise;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sclk_prev_r   <= 1'b0;
      slatch_prev_r <= 1'b1;
    end else begin
      sclk_prev_r   <= sclk_s;
      slatch_prev_r <= slatch_s;
    end
  end

  // Bits only shift while latch is low; data and clock share sync latency
  assign sclk_rise  = sclk_s && !sclk_prev_r && !slatch_s;
  assign latch_rise = slatch_s && !slatch_prev_r;

  // ----------------------------------------------------------------
  // Serial word collection
  // ----------------------------------------------------------------
  logic [synth_prog_pkg::WORD_W-1:0] shift_word;
  logic [7:0]                        shift_count;

  word_shifter #(
    .W (synth_prog_pkg::WORD_W)
  ) u_shifter (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .shift_en  (sclk_rise),
    .bit_in    (sdata_s),
    .clear     (latch_rise),
    .word      (shift_word),
    .bit_count (shift_count)
  );

  localparam logic [7:0] FULL_COUNT = 8'(synth_prog_pkg::WORD_W);

  // ----------------------------------------------------------------
  // Word decode
  // ----------------------------------------------------------------
  logic       word_ok;
  logic [3:0] sel;
  logic       wr_int;
  logic       wr_frac;
  logic       wr_aux_low;
  logic       wr_phase;
  logic       wr_rclk;
  logic       wr_aux_high;

  // Short or long words are dropped rather than half-applied
  assign word_ok = latch_rise && (shift_count == FULL_COUNT);
  assign sel     = shift_word[synth_prog_pkg::SEL_MSB:synth_prog_pkg::SEL_LSB];

  assign wr_int      = word_ok && (sel == synth_prog_pkg::SEL_INT_CTRL);
  assign wr_frac     = word_ok && (sel == synth_prog_pkg::SEL_MAIN_FRAC);
  assign wr_aux_low  = word_ok && (sel == synth_prog_pkg::SEL_AUX_LOW);
  assign wr_phase    = word_ok && (sel == synth_prog_pkg::SEL_PHASE_CTRL);
  assign wr_rclk     = word_ok && (sel == synth_prog_pkg::SEL_RESYNC_CLK);
  assign wr_aux_high = word_ok && (sel == synth_prog_pkg::SEL_AUX_HIGH);

  // ----------------------------------------------------------------
  // Shadow storage for double-buffered fields
  // ----------------------------------------------------------------
  logic [23:0] frac_shadow_r;
  logic [13:0] auxf_low_shadow_r;
  logic [13:0] auxm_low_shadow_r;
  logic [13:0] auxf_high_shadow_r;
  logic [13:0] auxm_high_shadow_r;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      frac_shadow_r <= '0;
    end else if (wr_frac) begin
      frac_shadow_r <= shift_word[synth_prog_pkg::FRAC_MSB:synth_prog_pkg::FRAC_LSB];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      auxf_low_shadow_r <= '0;
      auxm_low_shadow_r <= '0;
    end else if (wr_aux_low) begin
      auxf_low_shadow_r <= shift_word[synth_prog_pkg::AUXF_MSB:synth_prog_pkg::AUXF_LSB];
      auxm_low_shadow_r <= shift_word[synth_prog_pkg::AUXM_MSB:synth_prog_pkg::AUXM_LSB];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      auxf_high_shadow_r <= '0;
      auxm_high_shadow_r <= '0;
    end else if (wr_aux_high) begin
      auxf_high_shadow_r <= shift_word[synth_prog_pkg::AUXF_MSB:synth_prog_pkg::AUXF_LSB];
      auxm_high_shadow_r <= shift_word[synth_prog_pkg::AUXM_MSB:synth_prog_pkg::AUXM_LSB];
    end
  end

  // ----------------------------------------------------------------
  // Directly applied registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      phase_control <= synth_prog_pkg::PHASE_RESET;
    end else if (wr_phase) begin
      phase_control.modulator_reset_disable <= shift_word[synth_prog_pkg::SD_DIS_BIT];
      phase_control.resync_enable           <= shift_word[synth_prog_pkg::RESYNC_BIT];
      phase_control.phase_adjust_enable     <= shift_word[synth_prog_pkg::PADJ_BIT];
      phase_control.phase_value             <=
        shift_word[synth_prog_pkg::PHASE_MSB:synth_prog_pkg::PHASE_LSB];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      resync_clock_value <= '0;
    end else if (wr_rclk) begin
      resync_clock_value <= shift_word[synth_prog_pkg::RCLK_MSB:synth_prog_pkg::RCLK_LSB];
    end
  end

  // ----------------------------------------------------------------
  // Integer/control update: applies shadows to the active settings
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      active_settings <= synth_prog_pkg::SETTINGS_RESET;
    end else if (wr_int) begin
      active_settings.cal_enable    <= shift_word[synth_prog_pkg::CAL_BIT];
      active_settings.prescaler_89  <= shift_word[synth_prog_pkg::PRESC_BIT];
      active_settings.int_value     <=
        shift_word[synth_prog_pkg::INT_MSB:synth_prog_pkg::INT_LSB];
      active_settings.main_fraction <= frac_shadow_r;
      // High part times 2^14 plus low part is a plain concatenation
      active_settings.aux_fraction  <= {auxf_high_shadow_r, auxf_low_shadow_r};
      active_settings.aux_modulus   <= {auxm_high_shadow_r, auxm_low_shadow_r};
    end
  end

  // Disable bit is the value already held, not one in the same word
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      modulator_reset_pulse <= 1'b0;
    end else begin
      modulator_reset_pulse <= wr_int && !phase_control.modulator_reset_disable;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      calibration_start_pulse <= 1'b0;
    end else begin
      calibration_start_pulse <= wr_int && shift_word[synth_prog_pkg::CAL_BIT];
    end
  end

  // Band hold: update without calibration keeps the present band
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      vco_band_hold <= 1'b0;
    end else if (wr_int) begin
      vco_band_hold <= !shift_word[synth_prog_pkg::CAL_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      update_pulse <= 1'b0;
    end else begin
      update_pulse <= wr_int;
    end
  end

  // ----------------------------------------------------------------
  // Diagnostics of the last latched word; select code and reserved flag update only on full-length words
  // ----------------------------------------------------------------
  logic rsv_bad;

  // Host is meant to keep these zero; flagged, not enforced
  always_comb begin
    rsv_bad = 1'b0;
    case (sel)
      synth_prog_pkg::SEL_INT_CTRL: begin
        rsv_bad = |shift_word[synth_prog_pkg::RSV_INT_MSB:synth_prog_pkg::RSV_INT_LSB];
      end
      synth_prog_pkg::SEL_MAIN_FRAC: begin
        rsv_bad = |shift_word[synth_prog_pkg::RSV_FRAC_MSB:synth_prog_pkg::RSV_FRAC_LSB];
      end
      synth_prog_pkg::SEL_PHASE_CTRL: begin
        rsv_bad = shift_word[synth_prog_pkg::RSV_PH_BIT];
      end
      default: begin
        rsv_bad = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      reserved_bit_error <= 1'b0;
      last_select_code   <= '0;
    end else if (word_ok) begin
      reserved_bit_error <= rsv_bad;
      last_select_code   <= sel;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      word_length_error <= 1'b0;
    end else if (latch_rise) begin
      word_length_error <= (shift_count != FULL_COUNT);
    end
  end

  // ----------------------------------------------------------------
  // Layout checks
  // ----------------------------------------------------------------
  // Field slices above assume the package layout fits these widths
  if (synth_prog_pkg::SEL_MSB - synth_prog_pkg::SEL_LSB + 1
      != synth_prog_pkg::SEL_W) begin : g_bad_sel
    $error("Select field width disagrees with the package");
  end

  if (synth_prog_pkg::FRAC_MSB - synth_prog_pkg::FRAC_LSB + 1
      != $bits(frac_shadow_r)) begin : g_bad_frac
    $error("Main fraction field width disagrees with its shadow");
  end

  if (synth_prog_pkg::AUXF_MSB - synth_prog_pkg::AUXF_LSB + 1
      != synth_prog_pkg::AUX_PART_W) begin : g_bad_auxf
    $error("Aux fraction part width disagrees with the package");
  end

  if (synth_prog_pkg::AUXM_MSB - synth_prog_pkg::AUXM_LSB + 1
      != synth_prog_pkg::AUX_PART_W) begin : g_bad_auxm
    $error("Aux modulus part width disagrees with the package");
  end

  if (synth_prog_pkg::RCLK_MSB - synth_prog_pkg::RCLK_LSB + 1
      != $bits(resync_clock_value)) begin : g_bad_rclk
    $error("Resync clock field width disagrees with its output");
  end

endmodule

// ### design/synth_prog_pkg.sv
// Constants, field layouts and carriers for the synthesizer programming registers
// Operation
// - Select code 0000 routes the word to the integer/control register.
// - Select code 0001 routes the word to the main fraction register.
// - Select code 0010 routes the word to the auxiliary low register.
// - Select code 0011 routes the word to the phase/modulator control register.
// - Integer/control write with bit 21 set starts VCO band calibration.
// - With bit 21 clear, the update keeps the current VCO band.
// - Bit 20 selects the 4/5 or 8/9 prescaler.
// - Integer divide value is bits 19 to 4, sixteen bits.
// - Main fraction numerator is bits 27 to 4, twenty-four bits.
// - Aux fraction is high part bits 31:18 times 2^14 plus low part.
// - Aux modulus is high part bits 17:4 times 2^14 plus low part.
// - Integer/control write resets the modulator unless bit 30 of register 3 is set.
// - Buffered fields wait in shadow storage until the integer/control write.
package synth_prog_pkg;

  localparam int WORD_W = 32;
  localparam int SEL_W  = 4;
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 3;

  // Register select codes
  localparam logic [3:0] SEL_INT_CTRL   = 4'h0;
  localparam logic [3:0] SEL_MAIN_FRAC  = 4'h1;
  localparam logic [3:0] SEL_AUX_LOW    = 4'h2;
  localparam logic [3:0] SEL_PHASE_CTRL = 4'h3;
  localparam logic [3:0] SEL_RESYNC_CLK = 4'hc;
  localparam logic [3:0] SEL_AUX_HIGH   = 4'hd;

  // Integer/control register
  localparam int INT_LSB      = 4;
  localparam int INT_MSB      = 19;
  localparam int PRESC_BIT    = 20;
  localparam int CAL_BIT      = 21;
  localparam int RSV_INT_LSB  = 22;
  localparam int RSV_INT_MSB  = 31;

  // Main fraction register
  localparam int FRAC_LSB     = 4;
  localparam int FRAC_MSB     = 27;
  localparam int RSV_FRAC_LSB = 28;
  localparam int RSV_FRAC_MSB = 31;

  // Auxiliary fraction / modulus parts (same layout in low and high registers)
  localparam int AUX_PART_W   = 14;
  localparam int AUXF_LSB     = 18;
  localparam int AUXF_MSB     = 31;
  localparam int AUXM_LSB     = 4;
  localparam int AUXM_MSB     = 17;

  // Phase/modulator control register
  localparam int PHASE_LSB    = 4;
  localparam int PHASE_MSB    = 27;
  localparam int PADJ_BIT     = 28;
  localparam int RESYNC_BIT   = 29;
  localparam int SD_DIS_BIT   = 30;
  localparam int RSV_PH_BIT   = 31;

  // Resync clock register
  localparam int RCLK_LSB     = 12;
  localparam int RCLK_MSB     = 31;

  localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;

  typedef struct packed {
    logic        cal_enable;
    logic        prescaler_89;
    logic [15:0] int_value;
    logic [23:0] main_fraction;
    logic [27:0] aux_fraction;
    logic [27:0] aux_modulus;
  } divider_settings_s;

  typedef struct packed {
    logic        modulator_reset_disable;
    logic        resync_enable;
    logic        phase_adjust_enable;
    logic [23:0] phase_value;
  } phase_control_s;

  localparam divider_settings_s SETTINGS_RESET = '0;
  localparam phase_control_s    PHASE_RESET    = '0;

endpackage

// ### design/serial_front.sv
// Pin synchroniser and serial word shifter for the three-wire port
`timescale 1ns/1ps

// Reset level should match the idle level of the pin
module pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // Asynchronous pin in, synchronised level out
  input  wire logic pin_in,
  output logic      level_out
);

  logic meta_r;

  // First stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      meta_r    <= RESET_LEVEL;
      level_out <= RESET_LEVEL;
    end else begin
      meta_r    <= pin_in;
      level_out <= meta_r;
    end
  end

endmodule

module word_shifter #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          reset_n,
  // Control
  input  wire logic          shift_en,
  input  wire logic          bit_in,
  input  wire logic          clear,
  // Collected word and saturating bit count
  output logic [W-1:0]       word,
  output logic [7:0]         bit_count
);

  if (W < 8 || W > 255) begin : g_bad_width
    $error("word_shifter width out of range");
  end

  localparam logic [7:0] COUNT_MAX = 8'hff;

  // Most significant bit arrives first
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      word <= '0;
    end else if (shift_en) begin
      word <= {word[W-2:0], bit_in};
    end
  end

  // Clear wins over a same-cycle shift: latch edge closes the word
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      bit_count <= 8'h00;
    end else if (clear) begin
      bit_count <= 8'h00;
    end else if (shift_en && bit_count != COUNT_MAX) begin
      bit_count <= bit_count + 8'h01;
    end
  end

endmodule

// ### tb/host_serial_model.sv
// Host controller model driving the three-wire programming port
`timescale 1ns/1ps

module host_serial_model (
  // Clock
  input  wire logic        core_clk,
  // Request from the bench
  input  wire logic        go,
  input  wire logic [31:0] word,
  input  wire logic [6:0]  nbits,
  // Serial pins and completion
  output logic             sclk,
  output logic             sdata,
  output logic             slatch,
  output logic             done
);
  int i;

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Four core cycles per phase keeps above the synchroniser minimum
  initial begin
    sclk = 1'h0;
    sdata = 1'h0;
    slatch = 1'h1;
    done = 1'h0;
    forever begin
      @(posedge core_clk);
      if (go === 1'h1) begin
        #1;
        slatch = 1'h0;
        for (i = nbits - 1; i >= 0; i--) begin
          wait_cyc(4);
          sdata = word[i];
          wait_cyc(4);
          sclk = 1'h1;
          wait_cyc(4);
          sclk = 1'h0;
        end
        wait_cyc(4);
        slatch = 1'h1;
        // Released line shows no stale bit
        sdata = ~sdata;
        wait_cyc(8);
        done = 1'h1;
        wait_cyc(1);
        done = 1'h0;
      end
    end
  end
endmodule

// ### tb/synth_divider_program_regs_properties.sv
// Concurrent checks on the programming register outputs
`timescale 1ns/1ps

module synth_prog_checker (
  // Clock and reset
  input wire logic                         core_clk,
  input wire logic                         reset_n,
  // Observed outputs
  input synth_prog_pkg::divider_settings_s active_settings,
  input synth_prog_pkg::phase_control_s    phase_control,
  input wire logic [19:0]                  resync_clock_value,
  input wire logic                         modulator_reset_pulse,
  input wire logic                         calibration_start_pulse,
  input wire logic                         vco_band_hold,
  input wire logic                         update_pulse,
  input wire logic [3:0]                   last_select_code
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // ----------------
  // Update sequences
  // ----------------
  sequence s_upd;
    update_pulse;
  endsequence

  sequence s_upd_nocal;
    update_pulse && !active_settings.cal_enable;
  endsequence

  a_update_int_code: assert property (
    s_upd |-> last_select_code == synth_prog_pkg::SEL_INT_CTRL)
    else $error("update without integer code");
  a_pulse_single: assert property (s_upd |=> !update_pulse)
    else $error("update pulse too long");
  a_cal_start: assert property (
    calibration_start_pulse |-> update_pulse && active_settings.cal_enable)
    else $error("calibration start without enable");
  a_cal_skip: assert property (
    s_upd_nocal |-> !calibration_start_pulse && vco_band_hold)
    else $error("band not held");
  a_mod_reset: assert property (
    modulator_reset_pulse == (update_pulse && !phase_control.modulator_reset_disable))
    else $error("modulator reset mismatch");
  a_shadow_hold: assert property (!update_pulse |-> $stable(active_settings))
    else $error("settings moved without update");
  a_phase_direct: assert property (
    $changed(phase_control) |-> last_select_code == synth_prog_pkg::SEL_PHASE_CTRL)
    else $error("phase control from wrong code");
  a_resync_code: assert property (
    $changed(resync_clock_value) |-> last_select_code == synth_prog_pkg::SEL_RESYNC_CLK)
    else $error("resync value from wrong code");
endmodule

bind synth_divider_program_regs synth_prog_checker synth_prog_checker_inst (
  .core_clk(core_clk), .reset_n(reset_n), .active_settings(active_settings),
  .phase_control(phase_control), .resync_clock_value(resync_clock_value),
  .modulator_reset_pulse(modulator_reset_pulse),
  .calibration_start_pulse(calibration_start_pulse), .vco_band_hold(vco_band_hold),
  .update_pulse(update_pulse), .last_select_code(last_select_code));

// ### tb/synth_divider_program_regs_tb.sv
// Self-checking bench for the synthesizer programming registers
`timescale 1ns/1ps

module synth_divider_program_regs_tb;
  // Flags are {update, calibrate, modulator reset, reserved error, band hold}
  typedef struct packed {
    logic [31:0] w;
    logic [3:0]  sel;
    logic [4:0]  fl;
    logic [23:0] frac;
  } row_s;

  logic                              core_clk;
  logic                              reset_n;
  logic                              go;
  logic                              clr;
  logic [31:0]                       word;
  logic [6:0]                        nbits;
  logic                              sclk, sdata, slatch, done;
  synth_prog_pkg::divider_settings_s active_settings;
  synth_prog_pkg::divider_settings_s exp_set;
  synth_prog_pkg::phase_control_s    phase_control;
  logic [19:0]                       resync_clock_value;
  logic                              modulator_reset_pulse, calibration_start_pulse;
  logic                              vco_band_hold, update_pulse;
  logic [3:0]                        last_select_code, upd_cnt, cal_cnt, mrst_cnt;
  logic                              word_length_error, reserved_bit_error;
  int                                fail_count, checks_done, k;
  row_s                              rows [9] = '{
    '{32'h01234561, 4'h1, 5'h00, 24'h000000}, '{32'h6af01232, 4'h2, 5'h00, 24'h000000},
    '{32'h0014009d, 4'hd, 5'h00, 24'h000000}, '{32'h00312340, 4'h0, 5'h1c, 24'h123456},
    '{32'h7abcdef3, 4'h3, 5'h00, 24'h123456}, '{32'h00000500, 4'h0, 5'h11, 24'h123456},
    '{32'h1234500c, 4'hc, 5'h01, 24'h123456}, '{32'h00000005, 4'h5, 5'h01, 24'h123456},
    '{32'h80312340, 4'h0, 5'h1a, 24'h123456}};

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  // Pulses are counted so a doubled or missing pulse shows up
  always @(posedge core_clk) begin
    if (clr) begin
      upd_cnt <= 4'h0;
      cal_cnt <= 4'h0;
      mrst_cnt <= 4'h0;
    end else begin
      upd_cnt <= upd_cnt + update_pulse;
      cal_cnt <= cal_cnt + calibration_start_pulse;
      mrst_cnt <= mrst_cnt + modulator_reset_pulse;
    end
  end

  synth_divider_program_regs synth_divider_program_regs_inst (
    .core_clk(core_clk), .reset_n(reset_n), .serial_clk_pin(sclk),
    .serial_data_pin(sdata), .serial_latch_pin(slatch), .active_settings(active_settings),
    .phase_control(phase_control), .resync_clock_value(resync_clock_value),
    .modulator_reset_pulse(modulator_reset_pulse),
    .calibration_start_pulse(calibration_start_pulse), .vco_band_hold(vco_band_hold),
    .update_pulse(update_pulse), .last_select_code(last_select_code),
    .word_length_error(word_length_error), .reserved_bit_error(reserved_bit_error));

  host_serial_model host_serial_model_inst (
    .core_clk(core_clk), .go(go), .word(word), .nbits(nbits),
    .sclk(sclk), .sdata(sdata), .slatch(slatch), .done(done));

  task automatic results();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_set(input synth_prog_pkg::divider_settings_s got,
                         input synth_prog_pkg::divider_settings_s exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic send(input logic [31:0] w, input logic [6:0] n);
    int t;
    @(posedge core_clk);
    #1;
    word = w;
    nbits = n;
    go = 1'h1;
    clr = 1'h1;
    @(posedge core_clk);
    #1;
    go = 1'h0;
    clr = 1'h0;
    for (t = 0; t < 1000 && done !== 1'h1; t++) @(posedge core_clk);
    if (done !== 1'h1) begin
      fail_count++;
      results();
    end
    #1;
  endtask

  task automatic chk_zero();
    chk_set(active_settings, '0);
    chk_word({5'h0, phase_control}, 32'h0);
    chk_word({resync_clock_value, last_select_code, modulator_reset_pulse,
              calibration_start_pulse, vco_band_hold, update_pulse, word_length_error,
              reserved_bit_error, 2'h0}, 32'h0);
    // No false latch edge once the synchronisers fill
    repeat (4) @(posedge core_clk);
    #1;
    chk_word({31'h0, word_length_error}, 32'h0);
  endtask

  initial begin
    reset_n = 1'h0;
    go = 1'h0;
    clr = 1'h1;
    word = 32'h0;
    nbits = 7'h20;
    fail_count = 0;
    checks_done = 0;
    exp_set = {1'h1, 1'h1, 16'h1234, 24'h123456, 28'h0015abc, 28'h0024123};
    repeat (4) @(posedge core_clk);
    #1;
    reset_n = 1'h1;
    chk_zero();
    $display("test reset done");
    for (k = 0; k < 9; k++) begin
      send(rows[k].w, 7'h20);
      chk_word({28'h0, last_select_code}, {28'h0, rows[k].sel});
      chk_word({18'h0, upd_cnt, cal_cnt, mrst_cnt, reserved_bit_error, vco_band_hold},
               {18'h0, 3'h0, rows[k].fl[4], 3'h0, rows[k].fl[3], 3'h0, rows[k].fl[2],
                rows[k].fl[1:0]});
      chk_word({8'h0, active_settings.main_fraction}, {8'h0, rows[k].frac});
    end
    chk_set(active_settings, exp_set);
    chk_word({5'h0, phase_control}, {5'h0, 3'h7, 24'habcdef});
    chk_word({12'h0, resync_clock_value}, 32'h00012345);
    $display("test table done");
    send(32'h00000500, 7'h1f);
    chk_word({27'h0, upd_cnt, word_length_error}, 32'h00000001);
    chk_set(active_settings, exp_set);
    $display("test short word done");
    send(32'h10000011, 7'h20);
    chk_word({8'h0, active_settings.main_fraction}, 32'h00123456);
    chk_word({31'h0, reserved_bit_error}, 32'h00000001);
    send(32'h00000500, 7'h20);
    chk_word({8'h0, active_settings.main_fraction}, 32'h00000001);
    chk_word({20'h0, upd_cnt, mrst_cnt, 3'h0, word_length_error}, 32'h00000100);
    $display("test shadow done");
    reset_n = 1'h0;
    repeat (4) @(posedge core_clk);
    #1;
    reset_n = 1'h1;
    chk_zero();
    send(32'h00200500, 7'h20);
    chk_word({20'h0, upd_cnt, cal_cnt, mrst_cnt}, 32'h00000111);
    $display("test second reset done");
    results();
  end
endmodule
